// ==== logic/kbc_pkg.sv ====
/*
 * Constants of the controller's host command port and configuration byte.
 * Assumes an 8-bit host I/O port bus with one-cycle read and write strobes.
 */
//
// Contract
// - Mouse interrupt enable, config bit 1, resets to 0.
// - With bit 1 set, raise interrupt line 12 for mouse data in buffer.
// - Keyboard interrupt enable, config bit 0, resets to 0.
// - With bit 0 set, raise interrupt line 1 when buffer holds data; the code raises it only for non-mouse data.
// - Host writes command bytes to port 64; device decodes each one.
// - At power-up, port bits 3 to 6 load from strap inputs.
// - Set-high and set-low commands on pinless port bits complete normally.
// - Link clock/data and test bits stay owned by port logic, not commands.
// - Command 60h then a byte writes config; 20h returns config.
// - System flag, config bit 2, resets 0 and reads as status bit 2.
package kbc_pkg;
    // ****************************************************************
    // Host port addresses
    // ****************************************************************
    localparam logic [7:0] ADDR_DATA = 8'h60;
    localparam logic [7:0] ADDR_CMD = 8'h64;
    // ****************************************************************
    // Command codes
    // ****************************************************************
    localparam logic [7:0] CMD_READ_CFG = 8'h20;
    localparam logic [7:0] CMD_WRITE_CFG = 8'h60;
    localparam logic [3:0] CMD_NIBBLE_HI = 4'h9;
    localparam logic [3:0] CMD_PIN_HI = 4'hb;
    localparam logic [7:0] CMD_SELF_TEST = 8'haa;
    localparam logic [7:0] CMD_READ_IN = 8'hc0;
    localparam logic [7:0] CMD_READ_OUT = 8'hd0;
    localparam logic [7:0] CMD_WRITE_OUT = 8'hd1;
    localparam logic [7:0] CMD_READ_TEST = 8'he0;
    localparam logic [7:0] SELF_TEST_OK = 8'h55;
    // ****************************************************************
    // Configuration and status fields
    // ****************************************************************
    localparam int CFG_KBD_IRQ = 0;
    localparam int CFG_MOUSE_IRQ = 1;
    localparam int CFG_SYS_FLAG = 2;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int STS_OBF = 0;
    localparam int STS_SYS_FLAG = 2;
    localparam int STS_CMD_LAST = 3;
    localparam int STS_AUX = 5;
    // Port bit 3..6 come from straps; bits 0..1 belong to the link logic.
    localparam int STRAP_LO = 3;
    localparam int STRAP_HI = 6;
    localparam logic [7:0] PORT_RESET = 8'hff;
    localparam logic [7:0] PORT_LINK_MASK = 8'h03;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CFG = 2'b01,
        ST_OUTPORT = 2'b10
    } cmd_state_e;
endpackage : kbc_pkg

// ==== logic/kbc_cmd_port.sv ====
/*
 * Host command port, configuration byte, output buffer and interrupt
 * requests of the keyboard and mouse controller.
 * Assumes host strobes last one mclk cycle and the link logic presents
 * received bytes with a valid/ready handshake.
 */
`timescale 1ns/100ps
`default_nettype none
module kbc_cmd_port (
    input wire logic mclk,
    input wire logic reset,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic link_valid,
    input wire logic link_from_mouse,
    input wire logic [7:0] link_data,
    output logic link_ready,
    input wire logic [1:0] link_line_port_bits_low,
    input wire logic [1:0] test_input_bits,
    input wire logic [3:0] strap_port_bits,
    output logic [7:0] unused_port_bits,
    output logic irq1,
    output logic irq12
);
    // ****************************************************************
    // Host access decode
    // ****************************************************************
    logic [7:0] cfg_r;
    logic [7:0] port_r;
    logic [7:0] obf_data_r;
    logic obf_r;
    logic aux_r;
    logic cmd_last_r;
    logic strap_pending_r;
    kbc_pkg::cmd_state_e state_r;
    kbc_pkg::cmd_state_e state_nxt;

    wire cmd_wr = io_wr && (io_addr == kbc_pkg::ADDR_CMD);
    wire data_wr = io_wr && (io_addr == kbc_pkg::ADDR_DATA);
    wire data_rd = io_rd && (io_addr == kbc_pkg::ADDR_DATA);
    wire sts_rd = io_rd && (io_addr == kbc_pkg::ADDR_CMD);
    wire [3:0] cmd_hi = io_wdata[7:4];
    // Pin commands: bit 3 chooses high, bits 2..0 choose the pin.
    // The whole high nibble is compared, so that the Ax commands, self
    // test among them, never disturb a port bit.
    wire pin_cmd = cmd_wr && (cmd_hi == kbc_pkg::CMD_PIN_HI);
    wire pin_level = io_wdata[3];
    // Pins 2,3,6,7 map to port bits 2..5; the rest are link or second port.
    wire pin_writable = io_wdata[1];
    wire [2:0] pin_bit = io_wdata[2] ? {2'b10, io_wdata[0]} : io_wdata[2:0];
    wire nibble_cmd = cmd_wr && (cmd_hi == kbc_pkg::CMD_NIBBLE_HI);

    // ****************************************************************
    // Output port bits
    // ****************************************************************
    logic [7:0] port_nxt;
    always_comb begin
        port_nxt = port_r;
        if (strap_pending_r) begin
            port_nxt[kbc_pkg::STRAP_HI:kbc_pkg::STRAP_LO] = strap_port_bits;
        end else if (pin_cmd && pin_writable) begin
            port_nxt[pin_bit] = pin_level;
        end else if (nibble_cmd) begin
            port_nxt[3:0] = (port_r[3:0] & kbc_pkg::PORT_LINK_MASK[3:0])
                | (io_wdata[3:0] & ~kbc_pkg::PORT_LINK_MASK[3:0]);
        end else if (state_r == kbc_pkg::ST_OUTPORT && data_wr) begin
            port_nxt = (port_r & kbc_pkg::PORT_LINK_MASK)
                | (io_wdata & ~kbc_pkg::PORT_LINK_MASK);
        end
    end

    // ****************************************************************
    // Command sequencing and responses
    // ****************************************************************
    logic resp_load;
    logic [7:0] resp_data;
    always_comb begin
        state_nxt = state_r;
        resp_load = 1'b0;
        resp_data = 8'h00;
        if (cmd_wr) begin
            state_nxt = kbc_pkg::ST_IDLE;
            case (io_wdata)
                kbc_pkg::CMD_READ_CFG: begin
                    resp_load = 1'b1;
                    resp_data = cfg_r;
                end
                kbc_pkg::CMD_WRITE_CFG: begin
                    state_nxt = kbc_pkg::ST_CFG;
                end
                kbc_pkg::CMD_WRITE_OUT: begin
                    state_nxt = kbc_pkg::ST_OUTPORT;
                end
                kbc_pkg::CMD_SELF_TEST: begin
                    resp_load = 1'b1;
                    resp_data = kbc_pkg::SELF_TEST_OK;
                end
                kbc_pkg::CMD_READ_IN: begin
                    resp_load = 1'b1;
                    resp_data = {port_r[7:2], link_line_port_bits_low};
                end
                kbc_pkg::CMD_READ_OUT: begin
                    resp_load = 1'b1;
                    resp_data = port_r;
                end
                kbc_pkg::CMD_READ_TEST: begin
                    resp_load = 1'b1;
                    resp_data = {6'h00, test_input_bits};
                end
                default: begin
                    resp_load = 1'b0;
                end
            endcase
        end else if (data_wr) begin
            state_nxt = kbc_pkg::ST_IDLE;
        end
    end

    // Link bytes wait while the buffer is full or a response is loading.
    assign link_ready = !obf_r && !resp_load;
    wire link_load = link_valid && link_ready;
    wire obf_load = resp_load || link_load;

    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg_r <= kbc_pkg::CFG_RESET;
            state_r <= kbc_pkg::ST_IDLE;
            strap_pending_r <= 1'b1;
        end else begin
            if (state_r == kbc_pkg::ST_CFG && data_wr) begin
                cfg_r <= io_wdata;
            end
            state_r <= state_nxt;
            strap_pending_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            port_r <= kbc_pkg::PORT_RESET;
            obf_r <= 1'b0;
            aux_r <= 1'b0;
            obf_data_r <= 8'h00;
            cmd_last_r <= 1'b0;
        end else begin
            port_r <= port_nxt;
            // A load in the same cycle as a data read keeps the flag set.
            if (obf_load) begin
                obf_r <= 1'b1;
                obf_data_r <= resp_load ? resp_data : link_data;
                aux_r <= resp_load ? 1'b0 : link_from_mouse;
            end else if (data_rd) begin
                obf_r <= 1'b0;
            end
            if (io_wr) begin
                cmd_last_r <= cmd_wr;
            end
        end
    end

    // ****************************************************************
    // Host read data
    // ****************************************************************
    wire [7:0] status = {2'b00, aux_r, 1'b0, cmd_last_r,
        cfg_r[kbc_pkg::CFG_SYS_FLAG], 1'b0, obf_r};
    always_ff @(posedge mclk) begin
        if (reset) begin
            io_rdata <= 8'h00;
        end else if (data_rd) begin
            io_rdata <= obf_data_r;
        end else if (sts_rd) begin
            io_rdata <= status;
        end
    end

    assign unused_port_bits = port_r;
    // Levels derived from flops: they fall the cycle after the data read.
    assign irq1 = cfg_r[kbc_pkg::CFG_KBD_IRQ] && obf_r && !aux_r;
    assign irq12 = cfg_r[kbc_pkg::CFG_MOUSE_IRQ] && obf_r && aux_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_mouse_en_reset;
        @(posedge mclk) disable iff (reset)
        $past(reset) |-> !cfg_r[kbc_pkg::CFG_MOUSE_IRQ] && !irq12;
    endproperty
    a_mouse_en_reset: assert property (p_mouse_en_reset)
        else $error("mouse interrupt enable not clear after reset");

    property p_kbd_en_reset;
        @(posedge mclk) disable iff (reset)
        $past(reset) |-> !cfg_r[kbc_pkg::CFG_KBD_IRQ] && !irq1;
    endproperty
    a_kbd_en_reset: assert property (p_kbd_en_reset)
        else $error("keyboard interrupt enable not clear after reset");

    property p_irq12_mouse;
        @(posedge mclk) disable iff (reset)
        link_load && link_from_mouse && cfg_r[kbc_pkg::CFG_MOUSE_IRQ]
            && !(state_r == kbc_pkg::ST_CFG && data_wr) |=> irq12 && !irq1;
    endproperty
    a_irq12_mouse: assert property (p_irq12_mouse)
        else $error("mouse data did not raise interrupt 12");

    property p_irq1_kbd;
        @(posedge mclk) disable iff (reset)
        resp_load && cfg_r[kbc_pkg::CFG_KBD_IRQ] |=> irq1 && !irq12;
    endproperty
    a_irq1_kbd: assert property (p_irq1_kbd)
        else $error("buffer write did not raise interrupt 1");

    property p_read_drops;
        @(posedge mclk) disable iff (reset)
        data_rd && !obf_load |=> !irq1 && !irq12 && !obf_r;
    endproperty
    a_read_drops: assert property (p_read_drops)
        else $error("interrupt held after data port read");

    property p_cfg_write;
        @(posedge mclk) disable iff (reset)
        cmd_wr && io_wdata == kbc_pkg::CMD_WRITE_CFG ##1 data_wr
            |=> cfg_r == $past(io_wdata);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("configuration byte not written after 60h");

    property p_self_test;
        @(posedge mclk) disable iff (reset)
        cmd_wr && io_wdata == kbc_pkg::CMD_SELF_TEST
            |=> obf_r && obf_data_r == kbc_pkg::SELF_TEST_OK;
    endproperty
    a_self_test: assert property (p_self_test)
        else $error("self test command gave no answer");

    property p_sys_flag;
        @(posedge mclk) disable iff (reset)
        sts_rd |=> io_rdata[kbc_pkg::STS_SYS_FLAG]
            == $past(cfg_r[kbc_pkg::CFG_SYS_FLAG]);
    endproperty
    a_sys_flag: assert property (p_sys_flag)
        else $error("status bit 2 differs from system flag");

    property p_strap;
        @(posedge mclk) disable iff (reset)
        strap_pending_r |=> port_r[kbc_pkg::STRAP_HI:kbc_pkg::STRAP_LO]
            == $past(strap_port_bits);
    endproperty
    a_strap: assert property (p_strap)
        else $error("strap bits not loaded after reset");

    property p_link_bits;
        @(posedge mclk) disable iff (reset)
        cmd_wr |=> port_r[1:0] == $past(port_r[1:0]);
    endproperty
    a_link_bits: assert property (p_link_bits)
        else $error("command changed link line port bits");

    property p_pin_high;
        @(posedge mclk) disable iff (reset)
        pin_cmd && pin_writable && !strap_pending_r
            |=> port_r[$past(pin_bit)] == $past(pin_level);
    endproperty
    a_pin_high: assert property (p_pin_high)
        else $error("pin command did not complete");

    c_cfg_read: cover property (@(posedge mclk) disable iff (reset)
        cmd_wr && io_wdata == kbc_pkg::CMD_READ_CFG ##1 data_rd);
    c_mouse_irq: cover property (@(posedge mclk) disable iff (reset)
        irq12 ##1 data_rd);
    c_stall: cover property (@(posedge mclk) disable iff (reset)
        link_valid && !link_ready);
endmodule : kbc_cmd_port
`default_nettype wire

// ==== testbench/link_source.sv ====
/*
 * Model of the link logic that hands received bytes to the command port.
 * Assumes link_ready is combinational and settles before the falling edge.
 */
`timescale 1ns/100ps
`default_nettype none
module link_source (
    input wire logic mclk,
    input wire logic link_ready,
    output var logic link_valid,
    output var logic link_from_mouse,
    output var logic [7:0] link_data
);
    initial begin
        link_valid = 1'b0;
        link_from_mouse = 1'b0;
        link_data = 8'h00;
    end
    // Offer is held until accepted, for at most 200 cycles; ready is read at the falling edge so
    // the rising-edge update of the buffer flag cannot race the sample.
    // After release the lines show the inverse of the byte, not a copy.
    task automatic offer(input logic mouse, input logic [7:0] data,
                         output logic ok);
        ok = 1'b0;
        @(posedge mclk);
        #1;
        link_valid = 1'b1;
        link_from_mouse = mouse;
        link_data = data;
        for (int n = 0; n < 200 && !ok; n++) begin
            @(negedge mclk);
            ok = (link_ready === 1'b1);
            @(posedge mclk);
        end
        #1;
        link_valid = 1'b0;
        link_from_mouse = ~mouse;
        link_data = ~data;
    endtask : offer
endmodule : link_source
`default_nettype wire

// ==== testbench/testbench.sv ====
/*
 * Self-checking bench of the command port, configuration byte and
 * interrupt requests. Assumes the link_source model in its own file.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_addr = 8'h00;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    logic link_valid, link_from_mouse, link_ready, irq1, irq12;
    logic [7:0] link_data, unused_port_bits, rd, port_exp;
    int fails = 0;
    int check_count = 0;
    always #50 mclk = ~mclk;
    kbc_cmd_port i_dut (.mclk(mclk), .reset(reset), .io_wr(io_wr),
        .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .link_valid(link_valid),
        .link_from_mouse(link_from_mouse), .link_data(link_data),
        .link_ready(link_ready), .link_line_port_bits_low(2'b10),
        .test_input_bits(2'b01), .strap_port_bits(4'h5),
        .unused_port_bits(unused_port_bits), .irq1(irq1), .irq12(irq12));
    link_source i_link (.mclk(mclk), .link_ready(link_ready),
        .link_valid(link_valid), .link_from_mouse(link_from_mouse),
        .link_data(link_data));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic bus_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk);
        #1;
        io_wr = 1'b1;
        io_addr = addr;
        io_wdata = data;
        @(posedge mclk);
        #1;
        io_wr = 1'b0;
    endtask : bus_write
    task automatic bus_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge mclk);
        #1;
        io_rd = 1'b1;
        io_addr = addr;
        @(posedge mclk);
        #1;
        io_rd = 1'b0;
        data = io_rdata;
    endtask : bus_read
    task automatic cmd_read(input logic [7:0] cmd, output logic [7:0] data);
        bus_write(kbc_pkg::ADDR_CMD, cmd);
        bus_read(kbc_pkg::ADDR_DATA, data);
    endtask : cmd_read
    task automatic send(input logic m, input logic [7:0] d,
                        input logic [1:0] irq_exp);
        logic ok;
        i_link.offer(m, d, ok);
        if (ok !== 1'b1) begin
            fails++;
            $display("ERROR t=%0t got %h exp %h", $time, ok, 1'b1);
            report_and_stop();
        end else begin
            check({6'h00, irq12, irq1}, {6'h00, irq_exp});
            @(posedge mclk);
            #1;
            check({6'h00, irq12, irq1}, {6'h00, irq_exp});
            bus_read(kbc_pkg::ADDR_DATA, rd);
            check(rd, d);
            check({6'h00, irq12, irq1}, 8'h00);
        end
    endtask : send
    // Only pins 2, 3, 6 and 7 reach a port bit; the rest are swallowed.
    function automatic logic [7:0] pin_apply(input logic [7:0] p,
                                             input logic [3:0] c);
        logic [7:0] r;
        r = p;
        case (c[2:0])
            3'd2: r[2] = c[3];
            3'd3: r[3] = c[3];
            3'd6: r[4] = c[3];
            3'd7: r[5] = c[3];
            default: r = p;
        endcase
        return r;
    endfunction : pin_apply
    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        repeat (10) @(posedge mclk);
        #1;
        reset = 1'b0;
        @(posedge mclk);
        #1;
        check({6'h00, irq12, irq1}, 8'h00);
        port_exp = {1'b1, 4'h5, 3'b111};
        check(unused_port_bits, port_exp);
        cmd_read(kbc_pkg::CMD_READ_CFG, rd);
        check(rd, kbc_pkg::CFG_RESET);
        bus_read(kbc_pkg::ADDR_CMD, rd);
        check(rd, 8'h08);
        send(1'b0, 8'h3c, 2'b00);
        send(1'b1, 8'h4d, 2'b00);
        bus_write(kbc_pkg::ADDR_CMD, kbc_pkg::CMD_WRITE_CFG);
        bus_write(kbc_pkg::ADDR_DATA, 8'h02);
        send(1'b0, 8'h11, 2'b00);
        send(1'b1, 8'h22, 2'b10);
        bus_write(kbc_pkg::ADDR_CMD, kbc_pkg::CMD_WRITE_CFG);
        bus_write(kbc_pkg::ADDR_DATA, 8'h05);
        send(1'b0, 8'h33, 2'b01);
        send(1'b1, 8'h44, 2'b00);
        bus_write(kbc_pkg::ADDR_CMD, kbc_pkg::CMD_READ_CFG);
        check({6'h00, irq12, irq1}, 8'h01);
        bus_read(kbc_pkg::ADDR_CMD, rd);
        check(rd, 8'h0d);
        bus_read(kbc_pkg::ADDR_DATA, rd);
        check(rd, 8'h05);
        bus_write(8'h61, 8'h00);
        bus_write(8'h65, kbc_pkg::CMD_WRITE_CFG);
        bus_write(kbc_pkg::ADDR_DATA, 8'h00);
        cmd_read(kbc_pkg::CMD_READ_CFG, rd);
        check(rd, 8'h05);
        cmd_read(kbc_pkg::CMD_SELF_TEST, rd);
        check(rd, kbc_pkg::SELF_TEST_OK);
        for (int i = 0; i < 16; i++) begin
            bus_write(kbc_pkg::ADDR_CMD, {kbc_pkg::CMD_PIN_HI, 4'(i)});
            port_exp = pin_apply(port_exp, 4'(i));
            check(unused_port_bits, port_exp);
        end
        // Self test must leave a low port bit 2 alone.
        bus_write(kbc_pkg::ADDR_CMD, {kbc_pkg::CMD_PIN_HI, 4'h2});
        port_exp = pin_apply(port_exp, 4'h2);
        cmd_read(kbc_pkg::CMD_SELF_TEST, rd);
        check(unused_port_bits, port_exp);
        bus_write(kbc_pkg::ADDR_CMD, {kbc_pkg::CMD_NIBBLE_HI, 4'h0});
        port_exp[3:2] = 2'b00;
        check(unused_port_bits, port_exp);
        bus_write(kbc_pkg::ADDR_CMD, kbc_pkg::CMD_WRITE_OUT);
        bus_write(kbc_pkg::ADDR_DATA, 8'h00);
        port_exp[7:2] = 6'h00;
        check(unused_port_bits, port_exp);
        cmd_read(kbc_pkg::CMD_READ_OUT, rd);
        check(rd, port_exp);
        cmd_read(kbc_pkg::CMD_READ_IN, rd);
        check(rd & 8'h03, 8'h02);
        cmd_read(kbc_pkg::CMD_READ_TEST, rd);
        check(rd & 8'h03, 8'h01);
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
